// >>> hdl/rtc_bus_if.sv
// Purpose: Pin bundle between the clock device and its host
// Assumes: Pull-ups on data, reset and interrupt wires
// Notes:   Wire levels are resolved here from the drive enables
`timescale 1ns/1ps
interface rtc_bus_if;
    logic       ce_n;
    logic       oe_n;
    logic       we_n;
    logic [4:0] addr;
    logic [7:0] host_dq;
    logic       host_dq_oe;
    logic [7:0] dev_dq;
    logic       dev_dq_oe;
    logic       dev_rst_oe;
    logic       dev_irq_oe;
    logic [7:0] dq;
    logic       rst_n;
    logic       irq_n;

    // ==================================================================
    // Wire resolution; an undriven bus floats high on its pull-ups
    assign dq    = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 8'hFF);
    assign rst_n = ~dev_rst_oe;
    assign irq_n = ~dev_irq_oe;

    modport device (
        input  ce_n, oe_n, we_n, addr, dq,
        output dev_dq, dev_dq_oe, dev_rst_oe, dev_irq_oe
    );
    modport host (
        output ce_n, oe_n, we_n, addr, host_dq, host_dq_oe,
        input  dq, rst_n, irq_n
    );
endinterface

// >>> hdl/rtc_device.sv
// Purpose: Clock device end: bus slave, double-buffered BCD time, reset
// Assumes: vcc_ok_i high while supply is above the power-fail level
// Notes:   All pins pass a two-flop synchroniser, so bus timing is slow
// Functional notes
// - Read mode when chip, output enabled, write idle
// - Read data follows address without new edges
// - Drive data only with chip and output enabled
// - Write while chip and write enables low
// - Host holds address, separates cycles with idle
// - Data captured when write ends
// - Write enable falling stops read drive
// - Power fail blocks access, floats data and interrupt outputs, pulls reset
// - Reset output held low after power returns
// - Power-on reset independent of oscillator
// - Oscillator off until first main power
// - BCD time, 24-hour, byte access
// - Day of week steps at midnight
// - User copy refreshed once per second
// - Transfer disabled freezes user copy only
// - Update soon after transfer re-enabled
// - Re-enable loads written values into counters
// - Interrupt marks update, time stable until next
// - Host may repeat reads until two agree
// - Host freezes transfers before setting time
// - Month ends and leap years roll correctly
`timescale 1ns/1ps
module rtc_device #(
    parameter int unsigned TICK_CYCLES = rtc_pkg::TICK_CYCLES,
    parameter int unsigned HOLD_CYCLES = rtc_pkg::RESET_HOLD_CYCLES
) (
    input  logic      clock_i,
    input  logic      rst_b_i,
    rtc_bus_if.device bus,
    input  logic      vcc_ok_i,
    output logic      osc_enabled_o
);
    // ==================================================================
    // Time arithmetic
    function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
        if (v == hi)
            return lo;
        else if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        else
            return {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] bcd_bin(input logic [7:0] v);
        return {4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]};
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] m,
                                              input logic [7:0] y,
                                              input logic [7:0] c);
        logic [7:0] yb;
        logic       leap;
        yb   = bcd_bin(y);
        leap = (yb[1:0] == 2'b00) &&
               ((yb != 8'h00) || (bcd_bin(c) & 8'h03) == 8'h00);
        unique case (m)
            8'h02:                      return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default:                    return 8'h31;
        endcase
    endfunction

    function automatic rtc_pkg::time_t advance(input rtc_pkg::time_t t);
        rtc_pkg::time_t r;
        logic [7:0]     dim;
        r   = t;
        dim = month_days(t[5], t[6], t[7]);
        r[0] = bcd_next(t[0], rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX);
        if (t[0] == rtc_pkg::SEC_MAX) begin
            r[1] = bcd_next(t[1], rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX);
            if (t[1] == rtc_pkg::SEC_MAX) begin
                r[2] = bcd_next(t[2], rtc_pkg::BCD_ZERO,
                                rtc_pkg::HOUR_MAX);
                if (t[2] == rtc_pkg::HOUR_MAX) begin
                    r[3] = bcd_next(t[3], rtc_pkg::BCD_ONE,
                                    rtc_pkg::DAY_MAX);
                    r[4] = bcd_next(t[4], rtc_pkg::BCD_ONE, dim);
                    if (t[4] == dim) begin
                        r[5] = bcd_next(t[5], rtc_pkg::BCD_ONE,
                                        rtc_pkg::MONTH_MAX);
                        if (t[5] == rtc_pkg::MONTH_MAX) begin
                            r[6] = bcd_next(t[6], rtc_pkg::BCD_ZERO,
                                            rtc_pkg::YEAR_MAX);
                            if (t[6] == rtc_pkg::YEAR_MAX)
                                r[7] = bcd_next(t[7], rtc_pkg::BCD_ZERO,
                                                rtc_pkg::CENT_MAX);
                        end
                    end
                end
            end
        end
        return r;
    endfunction

    // ==================================================================
    // Pin synchroniser; stage one feeds stage two only
    logic [16:0] s1_q;
    logic [16:0] s2_q;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q <= rtc_pkg::SYNC_RST;
            s2_q <= rtc_pkg::SYNC_RST;
        end else begin
            s1_q <= {vcc_ok_i, bus.ce_n, bus.oe_n, bus.we_n, bus.addr,
                     bus.dq};
            s2_q <= s1_q;
        end
    end

    logic       vcc_ok;
    logic       ce_n;
    logic       oe_n;
    logic       we_n;
    logic [4:0] addr;
    logic [7:0] din;
    logic       rd_act;
    logic       wr_act;
    assign vcc_ok = s2_q[16];
    assign ce_n   = s2_q[15];
    assign oe_n   = s2_q[14];
    assign we_n   = s2_q[13];
    assign addr   = s2_q[12:8];
    assign din    = s2_q[7:0];
    // Supply below the trip level blocks every access
    assign rd_act = vcc_ok & ~ce_n & ~oe_n & we_n;
    assign wr_act = vcc_ok & ~ce_n & ~we_n;

    // ==================================================================
    // Timekeeping and register state
    rtc_pkg::time_t user_q, user_d, int_q, int_d;
    logic [7:0]  ctrl_b_q, ctrl_b_d, dout_q, dout_d;
    logic [31:0] tick_q, tick_d, hold_q, hold_d;
    logic irqf_q, irqf_d, eosc_n_q, eosc_n_d, powered_q, powered_d;
    logic dirty_q, dirty_d, rd_q, wr_q, dq_oe_q, dq_oe_d;
    logic rst_oe_q, rst_oe_d, irq_oe_q, irq_oe_d, osc_en_q;
    logic te, alarm_irq_enable, tick, wr_end, rd_end, hold_done;

    assign te        = ctrl_b_q[rtc_pkg::TE_BIT];
    assign alarm_irq_enable       = ctrl_b_q[rtc_pkg::TIE_BIT];
    // Tick counter runs only while the oscillator is enabled
    assign tick      = ~eosc_n_q && (tick_q == 32'(TICK_CYCLES - 1));
    assign wr_end    = wr_q & ~wr_act & vcc_ok;
    assign rd_end    = rd_q & ~rd_act & vcc_ok;
    assign hold_done = (hold_q == 32'(HOLD_CYCLES - 1));

    always_comb begin
        user_d    = user_q;
        int_d     = int_q;
        ctrl_b_d  = ctrl_b_q;
        irqf_d    = irqf_q;
        eosc_n_d  = eosc_n_q;
        powered_d = powered_q;
        dirty_d   = dirty_q;
        tick_d    = tick ? 32'h0 : (eosc_n_q ? tick_q : tick_q + 32'h1);
        if (vcc_ok && !powered_q) begin
            eosc_n_d  = 1'b0;
            powered_d = 1'b1;
        end
        // Internal set always advances; user set only while transferring
        if (tick) begin
            int_d = advance(int_q);
            if (te) begin
                user_d    = int_d;
                user_d[5] = (user_q[5] & rtc_pkg::MONTH_CTRL) | int_d[5];
            end
        end
        if (rd_end && addr == rtc_pkg::A_CTRL_A)
            irqf_d = 1'b0;
        if (tick && te && alarm_irq_enable)
            irqf_d = 1'b1;
        if (wr_end) begin
            if (addr[4:3] == 2'b00) begin
                user_d[addr[2:0]] = din;
                dirty_d = dirty_q | ~te;
                if (addr == rtc_pkg::A_MONTH)
                    eosc_n_d = din[rtc_pkg::EOSC_BIT];
            end else if (addr == rtc_pkg::A_CTRL_B) begin
                ctrl_b_d = din;
                if (din[rtc_pkg::TE_BIT] && !te) begin
                    // Unwritten freeze just resyncs the user copy at once
                    if (dirty_q) begin
                        int_d    = user_q;
                        int_d[5] = user_q[5] & rtc_pkg::MONTH_MASK;
                    end else begin
                        user_d    = int_q;
                        user_d[5] = (user_q[5] & rtc_pkg::MONTH_CTRL)
                                    | int_q[5];
                    end
                    dirty_d = 1'b0;
                end
            end
        end
    end

    // ==================================================================
    // Bus outputs and power-on reset
    always_comb begin
        dout_d = 8'h00;
        if (addr[4:3] == 2'b00) begin
            dout_d = user_q[addr[2:0]];
            if (addr == rtc_pkg::A_MONTH)
                dout_d[rtc_pkg::EOSC_BIT] = eosc_n_q;
        end else if (addr == rtc_pkg::A_CTRL_A) begin
            dout_d = {7'h00, irqf_q};
        end else if (addr == rtc_pkg::A_CTRL_B) begin
            dout_d = ctrl_b_q;
        end
        dq_oe_d  = rd_act;
        irq_oe_d = vcc_ok & irqf_q & alarm_irq_enable;
        // Counter runs on the system clock, never on the oscillator
        if (!vcc_ok)
            hold_d = 32'h0;
        else if (!hold_done)
            hold_d = hold_q + 32'h1;
        else
            hold_d = hold_q;
        rst_oe_d = ~vcc_ok | ~hold_done;
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            user_q    <= rtc_pkg::TIME_RST;
            int_q     <= rtc_pkg::TIME_RST;
            ctrl_b_q  <= rtc_pkg::CTRL_B_RST;
            irqf_q    <= 1'b0;
            eosc_n_q  <= 1'b1;
            powered_q <= 1'b0;
            dirty_q   <= 1'b0;
            tick_q    <= 32'h0;
            hold_q    <= 32'h0;
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
            dout_q    <= 8'h00;
            dq_oe_q   <= 1'b0;
            rst_oe_q  <= 1'b1;
            irq_oe_q  <= 1'b0;
            osc_en_q  <= 1'b0;
        end else begin
            user_q    <= user_d;
            int_q     <= int_d;
            ctrl_b_q  <= ctrl_b_d;
            irqf_q    <= irqf_d;
            eosc_n_q  <= eosc_n_d;
            powered_q <= powered_d;
            dirty_q   <= dirty_d;
            tick_q    <= tick_d;
            hold_q    <= hold_d;
            rd_q      <= rd_act;
            wr_q      <= wr_act;
            dout_q    <= dout_d;
            dq_oe_q   <= dq_oe_d;
            rst_oe_q  <= rst_oe_d;
            irq_oe_q  <= irq_oe_d;
            osc_en_q  <= ~eosc_n_d;
        end
    end

    assign bus.dev_dq     = dout_q;
    assign bus.dev_dq_oe  = dq_oe_q;
    assign bus.dev_rst_oe = rst_oe_q;
    assign bus.dev_irq_oe = irq_oe_q;
    assign osc_enabled_o  = osc_en_q;
endmodule // rtc_device

// >>> hdl/rtc_host.sv
// Purpose: Host end: turns byte requests into bus read and write cycles
// Assumes: One request at a time, taken only while req_ready_o is high
// Notes:   Strobe is long enough for the device synchroniser to settle
`timescale 1ns/1ps
module rtc_host (
    input  logic       clock_i,
    input  logic       rst_b_i,
    rtc_bus_if.host    bus,
    input  logic       req_valid_i,
    input  logic       req_write_i,
    input  logic [4:0] req_addr_i,
    input  logic [7:0] req_wdata_i,
    output logic       req_ready_o,
    output logic       rsp_valid_o,
    output logic [7:0] rsp_rdata_o,
    output logic       dev_reset_o,
    output logic       dev_irq_o
);
    typedef enum logic [2:0] {
        IDLE   = 3'b000,
        SETUP  = 3'b001,
        STROBE = 3'b010,
        HOLD   = 3'b011,
        GAP    = 3'b100
    } host_state_t;

    // ==================================================================
    // Pin synchroniser for data, reset and interrupt
    logic [9:0] s1_q;
    logic [9:0] s2_q;
    logic       rst_seen_q;
    logic       irq_seen_q;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q       <= 10'h3FF;
            s2_q       <= 10'h3FF;
            rst_seen_q <= 1'b0;
            irq_seen_q <= 1'b0;
        end else begin
            s1_q       <= {bus.rst_n, bus.irq_n, bus.dq};
            s2_q       <= s1_q;
            // Extra stage so both status outputs leave straight from a flop
            rst_seen_q <= ~s2_q[9];
            irq_seen_q <= ~s2_q[8];
        end
    end

    // ==================================================================
    // Cycle sequencer
    host_state_t st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [4:0]  addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d, rdata_q, rdata_d;
    logic        wr_q, wr_d, ce_n_q, ce_n_d, oe_n_q, oe_n_d;
    logic        we_n_q, we_n_d, doe_q, doe_d, rv_q, rv_d, rdy_q, rdy_d;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q + 4'h1;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        wr_d    = wr_q;
        ce_n_d  = ce_n_q;
        oe_n_d  = oe_n_q;
        we_n_d  = we_n_q;
        doe_d   = doe_q;
        rv_d    = 1'b0;
        unique case (st_q)
            IDLE: begin
                cnt_d = 4'h0;
                if (req_valid_i) begin
                    addr_d  = req_addr_i;
                    wdata_d = req_wdata_i;
                    wr_d    = req_write_i;
                    doe_d   = req_write_i;
                    st_d    = SETUP;
                end
            end
            SETUP: begin
                cnt_d  = 4'h0;
                ce_n_d = 1'b0;
                we_n_d = ~wr_q;
                oe_n_d = wr_q;
                st_d   = STROBE;
            end
            STROBE: begin
                if (cnt_q == rtc_pkg::STROBE_CYCLES - 4'h1) begin
                    ce_n_d  = 1'b1;
                    we_n_d  = 1'b1;
                    oe_n_d  = 1'b1;
                    rdata_d = wr_q ? rdata_q : s2_q[7:0];
                    rv_d    = ~wr_q;
                    cnt_d   = 4'h0;
                    st_d    = HOLD;
                end
            end
            HOLD: begin
                // Data and address stay past the closing edge
                if (cnt_q == rtc_pkg::HOLD_CYCLES - 4'h1) begin
                    doe_d = 1'b0;
                    cnt_d = 4'h0;
                    st_d  = GAP;
                end
            end
            GAP: begin
                if (cnt_q == rtc_pkg::GAP_CYCLES - 4'h1)
                    st_d = IDLE;
            end
            default: st_d = IDLE;
        endcase
        rdy_d = (st_d == IDLE);
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q    <= IDLE;
            cnt_q   <= 4'h0;
            addr_q  <= 5'h00;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            wr_q    <= 1'b0;
            ce_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            we_n_q  <= 1'b1;
            doe_q   <= 1'b0;
            rv_q    <= 1'b0;
            rdy_q   <= 1'b1;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            wr_q    <= wr_d;
            ce_n_q  <= ce_n_d;
            oe_n_q  <= oe_n_d;
            we_n_q  <= we_n_d;
            doe_q   <= doe_d;
            rv_q    <= rv_d;
            rdy_q   <= rdy_d;
        end
    end

    assign bus.ce_n       = ce_n_q;
    assign bus.oe_n       = oe_n_q;
    assign bus.we_n       = we_n_q;
    assign bus.addr       = addr_q;
    assign bus.host_dq    = wdata_q;
    assign bus.host_dq_oe = doe_q;
    assign req_ready_o    = rdy_q;
    assign rsp_valid_o    = rv_q;
    assign rsp_rdata_o    = rdata_q;
    assign dev_reset_o    = rst_seen_q;
    assign dev_irq_o      = irq_seen_q;
endmodule // rtc_host

// >>> hdl/rtc_pkg.sv
// Purpose: Shared constants and types for the parallel-bus BCD clock
// Assumes: 200 MHz system clock, byte-wide asynchronous bus
// Notes:   Long counts are defaults; the top modules take them as parameters
package rtc_pkg;
    // ==================================================================
    // Bus widths and register addresses
    localparam int        ADDR_W  = 5;
    localparam int        DATA_W  = 8;
    localparam logic [4:0] A_SEC    = 5'h00;
    localparam logic [4:0] A_MIN    = 5'h01;
    localparam logic [4:0] A_HOUR   = 5'h02;
    localparam logic [4:0] A_DAY    = 5'h03;
    localparam logic [4:0] A_DATE   = 5'h04;
    localparam logic [4:0] A_MONTH  = 5'h05;
    localparam logic [4:0] A_YEAR   = 5'h06;
    localparam logic [4:0] A_CENT   = 5'h07;
    localparam logic [4:0] A_CTRL_A = 5'h0E;
    localparam logic [4:0] A_CTRL_B = 5'h0F;

    // ==================================================================
    // Field positions and masks
    localparam int        TE_BIT     = 7;
    localparam int        TIE_BIT    = 3;
    localparam int        EOSC_BIT   = 7;
    localparam logic [7:0] MONTH_MASK = 8'h1F;
    localparam logic [7:0] MONTH_CTRL = 8'h60;

    // ==================================================================
    // BCD limits
    localparam logic [7:0] SEC_MAX   = 8'h59;
    localparam logic [7:0] HOUR_MAX  = 8'h23;
    localparam logic [7:0] DAY_MAX   = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX  = 8'h99;
    localparam logic [7:0] CENT_MAX  = 8'h39;
    localparam logic [7:0] BCD_ONE   = 8'h01;
    localparam logic [7:0] BCD_ZERO  = 8'h00;

    // ==================================================================
    // Types and values after reset
    typedef logic [7:0][7:0] time_t;
    localparam time_t       TIME_RST   = 64'h0000010101000000;
    localparam logic [7:0]  CTRL_B_RST = 8'h80;
    localparam logic [16:0] SYNC_RST   = 17'h0E000;

    // ==================================================================
    // Timing
    localparam int unsigned CLK_MHZ           = 200;
    localparam int unsigned TICK_CYCLES       = CLK_MHZ * 1000000;
    localparam int unsigned RESET_HOLD_MS     = 200;
    localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_MS * CLK_MHZ
                                                * 1000;
    localparam int unsigned TE_HOLD_US        = 366;
    localparam int unsigned TE_HOLD_CYCLES    = TE_HOLD_US * CLK_MHZ;
    localparam logic [3:0]  STROBE_CYCLES     = 4'h8;
    localparam logic [3:0]  HOLD_CYCLES       = 4'h2;
    localparam logic [3:0]  GAP_CYCLES        = 4'h4;
endpackage

// >>> testbench/parallel_bus_bcd_rtc_test.sv
// Purpose: Drives the host request port against the real device end
// Assumes: Short tick and reset hold counts for a brief run
// Notes:   Irq marks each update, used to read time coherently
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module parallel_bus_bcd_rtc_test;
    localparam int unsigned TICK = 2000;
    localparam int unsigned HOLD = 20;
    logic       clock_i;
    logic       rst_b_i;
    logic       vcc_ok_i;
    logic       osc_enabled_o;
    logic       req_valid_i;
    logic       req_write_i;
    logic [4:0] req_addr_i;
    logic [7:0] req_wdata_i;
    logic       req_ready_o;
    logic       rsp_valid_o;
    logic [7:0] rsp_rdata_o;
    logic       dev_reset_o;
    logic       dev_irq_o;
    logic [7:0] rv;
    int         err_count = 0;
    int         checked = 0;
    logic [7:0] set_v [8] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02,
                              8'h24, 8'h20};
    logic [7:0] nxt_v [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02,
                              8'h24, 8'h20};

    rtc_bus_if bus ();
    rtc_device #(.TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD)) i_rtc_device (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .bus(bus),
        .vcc_ok_i(vcc_ok_i), .osc_enabled_o(osc_enabled_o));
    rtc_host i_rtc_host (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .bus(bus),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .dev_reset_o(dev_reset_o),
        .dev_irq_o(dev_irq_o));
    rtc_bus_sva #(.HOLD_CYCLES(HOLD)) i_rtc_bus_sva (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .vcc_ok_i(vcc_ok_i),
        .osc_enabled_o(osc_enabled_o), .ce_n(bus.ce_n), .oe_n(bus.oe_n),
        .we_n(bus.we_n), .addr(bus.addr), .host_dq_oe(bus.host_dq_oe),
        .dev_dq_oe(bus.dev_dq_oe), .dev_rst_oe(bus.dev_rst_oe),
        .dev_irq_oe(bus.dev_irq_oe));

    // ==================================================================
    // Request tasks; inputs move 1 ns after the rising edge
    task automatic req(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 100) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        req_valid_i = 1'b1;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        @(posedge clock_i);
        #1;
        req_valid_i = 1'b0;
    endtask

    task automatic rd(input logic [4:0] a);
        int n;
        n = 0;
        req(1'b0, a, 8'h00);
        while (rsp_valid_o !== 1'b1 && n < 40) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        rv = rsp_rdata_o;
    endtask

    task automatic wait_cyc(input int unsigned c);
        repeat (c) @(posedge clock_i);
        #1;
    endtask

    task automatic final_report();
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==================================================================
    // Clock, watchdog and test sequence
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        wait_cyc(30000);
        err_count++;
        final_report();
    end
    initial begin
        rst_b_i = 1'b0;
        vcc_ok_i = 1'b1;
        req_valid_i = 1'b0;
        req_write_i = 1'b0;
        req_addr_i = 5'h00;
        req_wdata_i = 8'h00;
        wait_cyc(5);
        `CHK(osc_enabled_o, 1'b0)
        rst_b_i = 1'b1;
        wait_cyc(3);
        `CHK(dev_reset_o, 1'b1)
        wait_cyc(HOLD + 10);
        `CHK(dev_reset_o, 1'b0)
        `CHK(osc_enabled_o, 1'b1)
        rd(rtc_pkg::A_CTRL_B);
        `CHK(rv, 8'h80)
        rd(5'h08);
        `CHK(rv, 8'h00)
        // Freeze first so a tick cannot split the new setting
        req(1'b1, rtc_pkg::A_CTRL_B, 8'h00);
        for (int i = 0; i < 8; i++) req(1'b1, 5'(i), set_v[i]);
        req(1'b1, rtc_pkg::A_CTRL_B, 8'h88);
        rd(rtc_pkg::A_CTRL_A);
        wait_cyc(4);
        for (int n = 0; n < 3 * TICK && dev_irq_o !== 1'b1; n++) wait_cyc(1);
        rd(rtc_pkg::A_CTRL_A);
        `CHK(rv, 8'h01)
        for (int i = 0; i < 8; i++) begin
            rd(5'(i));
            `CHK(rv, nxt_v[i])
        end
        `CHK(dev_irq_o, 1'b0)
        req(1'b1, rtc_pkg::A_CTRL_B, 8'h08);
        wait_cyc(TICK + 100);
        rd(rtc_pkg::A_SEC);
        `CHK(rv, 8'h00)
        `CHK(dev_irq_o, 1'b0)
        req(1'b1, rtc_pkg::A_CTRL_B, 8'h80);
        rd(rtc_pkg::A_SEC);
        `CHK(rv, 8'h01)
        // Second read must agree with the first within the same second
        rd(rtc_pkg::A_SEC);
        `CHK(rv, 8'h01)
        vcc_ok_i = 1'b0;
        wait_cyc(8);
        `CHK(dev_reset_o, 1'b1)
        rd(rtc_pkg::A_SEC);
        `CHK(rv, 8'hFF)
        vcc_ok_i = 1'b1;
        wait_cyc(HOLD / 2);
        `CHK(dev_reset_o, 1'b1)
        wait_cyc(HOLD + 10);
        `CHK(dev_reset_o, 1'b0)
        final_report();
    end
endmodule // parallel_bus_bcd_rtc_test

// >>> testbench/rtc_bus_sva.sv
// Purpose: Checks the clock device and host pins across the bus bundle
// Assumes: Instantiated beside the bundle, names matched one to one
// Notes:   Pins pass a two-flop synchroniser, so delays carry a margin
`timescale 1ns/1ps
module rtc_bus_sva #(
    parameter int unsigned HOLD_CYCLES = 20
) (
    input logic       clock_i,
    input logic       rst_b_i,
    input logic       vcc_ok_i,
    input logic       osc_enabled_o,
    input logic       ce_n,
    input logic       oe_n,
    input logic       we_n,
    input logic [4:0] addr,
    input logic       host_dq_oe,
    input logic       dev_dq_oe,
    input logic       dev_rst_oe,
    input logic       dev_irq_oe
);
    logic        rd_w;
    logic [15:0] up_q;
    logic [15:0] up_d;

    // ==================================================================
    // Supply-up counter; saturates so a long run never wraps
    assign rd_w = !ce_n && !oe_n && we_n;
    always_comb begin
        up_d = 16'h0000;
        if (vcc_ok_i) begin
            up_d = (up_q == 16'hFFFF) ? up_q : up_q + 16'h0001;
        end
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            up_q <= 16'h0000;
        end else begin
            up_q <= up_d;
        end
    end

    // ==================================================================
    // Properties
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    AST_READ_DRIVE: assert property (
        $rose(dev_dq_oe) |-> $past(rd_w, 3))
        else $error("data driven without a read");
    AST_IDLE_FLOAT: assert property (
        !rd_w [*5] |-> !dev_dq_oe)
        else $error("data driven while deselected");
    // Write enable low must silence the data pins after the sync delay
    AST_WE_STOPS_DRIVE: assert property (
        !we_n |-> ##3 !dev_dq_oe)
        else $error("data still driven during write");
    AST_PF_FLOAT: assert property (
        !vcc_ok_i [*5] |-> !dev_dq_oe && !dev_irq_oe)
        else $error("outputs active during power fail");
    AST_PF_RESET: assert property (
        !vcc_ok_i [*5] |-> dev_rst_oe)
        else $error("reset not pulled during power fail");
    AST_RST_HOLD: assert property (
        up_q != 0 && up_q <= HOLD_CYCLES |-> dev_rst_oe)
        else $error("reset released too early");
    AST_RST_FREE: assert property (
        up_q == HOLD_CYCLES + 8 |-> !dev_rst_oe)
        else $error("reset held too long");
    AST_OSC_ON: assert property (
        up_q == 16'h0008 |-> osc_enabled_o)
        else $error("oscillator not started by power");
    AST_ADDR_STABLE: assert property (
        !ce_n && !we_n && !$past(ce_n) && !$past(we_n) |-> $stable(addr))
        else $error("address moved during write");
    AST_CYCLE_GAP: assert property (
        $rose(ce_n) |-> ce_n [*4])
        else $error("no idle gap between cycles");
    AST_WDATA_HOLD: assert property (
        $rose(we_n) |-> host_dq_oe ##1 host_dq_oe)
        else $error("write data dropped at write end");

    cover property ($rose(dev_dq_oe));
    cover property ($rose(we_n));
    cover property ($fell(dev_rst_oe));
    cover property ($rose(dev_irq_oe));
endmodule // rtc_bus_sva
